// ==== hdl/mib_pkg.sv ====
// Constants, offsets and field layout of the statistics counter block.
// Assumes a single core clock domain and an AXI4-Lite register bus.
//
// Function
// - Counters are read only indirectly via per-port control/status and data registers.
// - Reading a counter clears it, returning counts since the last read.
// - Bit 25 starts a read; index and start may share a write.
// - Bit 25 stays one while reading, drops to zero when count valid.
// - Value sits in data register; bits [35:32] appear in control/status.
// - Overflow flag of the read counter appears in control/status register.
// - Freeze and flush act only on ports with their enable set.
// - Control/status bit 24 enables the port for freeze and flush.
// - Writing 0x40 to switch control freezes counters of enabled ports.
// - Writing 0xC0 clears enabled ports' counters while keeping them frozen.
// - Writing 0x00 releases freeze and flush; counting resumes.
// - Ordinary counters are 30 bits; byte counters are wider, 36 bits.

package mib_pkg;

   // *********************************************************************
   // Sizes
   // *********************************************************************
   localparam int NPORT   = 3;
   localparam int NSLOT   = 36;
   localparam int CNT_W   = 36;
   localparam int SHORT_W = 30;
   localparam int BYTE_W  = 14;
   localparam int IDX_W   = 8;
   localparam int HI_W    = 4;
   localparam int SLOT_W  = 6;
   localparam int IRQ_W   = 2 * NPORT;

   // *********************************************************************
   // Register byte addresses
   // *********************************************************************
   localparam logic [11:0] ADDR_SW_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_IRQ_STAT  = 12'h004;
   localparam logic [11:0] ADDR_IRQ_MASK  = 12'h008;
   localparam logic [11:0] ADDR_PORT_BASE = 12'h100;
   localparam logic [11:0] PORT_STRIDE    = 12'h010;
   localparam logic [11:0] DATA_OFS       = 12'h004;

   // *********************************************************************
   // Field positions
   // *********************************************************************
   localparam int CSR_OVF_BIT   = 31;
   localparam int CSR_START_BIT = 25;
   localparam int CSR_EN_BIT    = 24;
   localparam int CSR_IDX_LSB   = 16;
   localparam int SW_FREEZE_BIT = 6;
   localparam int SW_FLUSH_BIT  = 7;

   // *********************************************************************
   // Counter indices and reset values
   // *********************************************************************
   localparam logic [7:0]  IDX_HIGH_BASE = 8'h80;
   localparam int          SLOT_RX_BYTES = 32;
   localparam int          SLOT_TX_BYTES = 33;
   localparam logic [31:0] RST_WORD      = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

// ==== hdl/mib_counter_access_freeze.sv ====
// Per-port statistics counters with indirect read-clear access and freeze.
// Assumes synchronous event inputs and an AXI4-Lite master on sys_clk.
`timescale 1ns/1ns
`default_nettype none

module mib_counter_access_freeze
(
   input  wire logic                                   sys_clk,
   input  wire logic                                   rst,
   input  wire logic                                   ce,
   input  wire logic [mib_pkg::NPORT*mib_pkg::NSLOT-1:0] cnt_evt,
   input  wire logic [mib_pkg::NPORT*mib_pkg::BYTE_W-1:0] rx_bytes,
   input  wire logic [mib_pkg::NPORT*mib_pkg::BYTE_W-1:0] tx_bytes,
   input  wire logic [11:0]                            s_axi_awaddr,
   input  wire logic                                   s_axi_awvalid,
   output logic                                        s_axi_awready,
   input  wire logic [31:0]                            s_axi_wdata,
   input  wire logic [3:0]                             s_axi_wstrb,
   input  wire logic                                   s_axi_wvalid,
   output logic                                        s_axi_wready,
   output logic [1:0]                                  s_axi_bresp,
   output logic                                        s_axi_bvalid,
   input  wire logic                                   s_axi_bready,
   input  wire logic [11:0]                            s_axi_araddr,
   input  wire logic                                   s_axi_arvalid,
   output logic                                        s_axi_arready,
   output logic [31:0]                                 s_axi_rdata,
   output logic [1:0]                                  s_axi_rresp,
   output logic                                        s_axi_rvalid,
   input  wire logic                                   s_axi_rready,
   output logic                                        irq
);

   // *********************************************************************
   // Declarations
   // *********************************************************************
   logic [11:0]            awaddr_q;
   logic                   aw_held_q;
   logic [31:0]            wdata_q;
   logic [3:0]             wstrb_q;
   logic                   w_held_q;
   logic                   bvalid_q;
   logic [1:0]             bresp_q;
   logic                   rvalid_q;
   logic [31:0]            rdata_q;
   logic [1:0]             rresp_q;
   logic                   wr_fire;
   logic                   rd_fire;
   logic [31:0]            rd_word;
   logic                   rd_ok;
   logic                   wr_ok;
   logic [7:0]             sw_ctrl_q;
   logic [mib_pkg::IRQ_W-1:0] irq_stat_q;
   logic [mib_pkg::IRQ_W-1:0] irq_mask_q;
   logic [mib_pkg::IRQ_W-1:0] irq_evt;
   logic [31:0]               mask_wr;
   logic [mib_pkg::NPORT-1:0] en_q;
   logic [mib_pkg::NPORT-1:0] busy_q;
   logic [mib_pkg::NPORT-1:0] ovf_rd_q;
   logic [mib_pkg::NPORT-1:0] csr_wr;
   logic [mib_pkg::NPORT-1:0] hold;
   logic [mib_pkg::NPORT-1:0] clear_all;
   logic [mib_pkg::IDX_W-1:0] idx_q    [mib_pkg::NPORT];
   logic [31:0]               data_q   [mib_pkg::NPORT];
   logic [mib_pkg::HI_W-1:0]  hi_q     [mib_pkg::NPORT];
   logic [mib_pkg::CNT_W-1:0] cnt_q    [mib_pkg::NPORT][mib_pkg::NSLOT];
   logic                      ovf_q    [mib_pkg::NPORT][mib_pkg::NSLOT];
   logic [mib_pkg::NSLOT-1:0] wrap     [mib_pkg::NPORT];
   logic [mib_pkg::SLOT_W-1:0] sel_slot [mib_pkg::NPORT];
   logic [mib_pkg::NPORT-1:0] sel_ok;

   // Maps a counter index onto a storage slot; bit 6 flags a valid index.
   function automatic logic [mib_pkg::SLOT_W:0] slot_of
   (
      input logic [mib_pkg::IDX_W-1:0] idx
   );
      logic [mib_pkg::SLOT_W:0] r;
      r = '0;
      if (idx[7:5] == 3'h0)
      begin
         r = {2'b10, idx[4:0]};
      end
      else if ((idx & 8'hFC) == mib_pkg::IDX_HIGH_BASE)
      begin
         r = {5'b11000, idx[1:0]};
      end
      return r;
   endfunction

   // Applies byte strobes to a stored word.
   function automatic logic [31:0] merge
   (
      input logic [31:0] old,
      input logic [31:0] nw,
      input logic [3:0]  st
   );
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (st[b])
         begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // *********************************************************************
   // AXI4-Lite slave
   // *********************************************************************
   assign s_axi_awready = ce & ~aw_held_q & ~bvalid_q;
   assign s_axi_wready  = ce & ~w_held_q & ~bvalid_q;
   assign s_axi_arready = ce & ~rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign wr_fire       = ce & aw_held_q & w_held_q & ~bvalid_q;
   assign rd_fire       = s_axi_arvalid & s_axi_arready;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         awaddr_q  <= 12'h000;
         wdata_q   <= mib_pkg::RST_WORD;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= mib_pkg::RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_ok ? mib_pkg::RESP_OKAY : mib_pkg::RESP_SLVERR;
         end
         else if (bvalid_q && s_axi_bready)
         begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rvalid_q <= 1'b0;
         rdata_q  <= mib_pkg::RST_WORD;
         rresp_q  <= mib_pkg::RESP_OKAY;
      end
      else if (ce)
      begin
         if (rd_fire)
         begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_ok ? mib_pkg::RESP_OKAY : mib_pkg::RESP_SLVERR;
         end
         else if (rvalid_q && s_axi_rready)
         begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // *********************************************************************
   // Address decode and read mux
   // *********************************************************************
   always_comb
   begin
      logic [11:0] a;
      a       = 12'h000;
      rd_word = mib_pkg::RST_WORD;
      rd_ok   = 1'b0;
      wr_ok   = 1'b0;
      csr_wr  = '0;
      case (s_axi_araddr)
         mib_pkg::ADDR_SW_CTRL:
         begin
            rd_word = {24'h00_0000, sw_ctrl_q};
            rd_ok   = 1'b1;
         end
         mib_pkg::ADDR_IRQ_STAT:
         begin
            rd_word = {26'h000_0000, irq_stat_q};
            rd_ok   = 1'b1;
         end
         mib_pkg::ADDR_IRQ_MASK:
         begin
            rd_word = {26'h000_0000, irq_mask_q};
            rd_ok   = 1'b1;
         end
         default:
         begin
            rd_ok = 1'b0;
         end
      endcase
      if (awaddr_q == mib_pkg::ADDR_SW_CTRL ||
          awaddr_q == mib_pkg::ADDR_IRQ_STAT ||
          awaddr_q == mib_pkg::ADDR_IRQ_MASK)
      begin
         wr_ok = 1'b1;
      end
      for (int p = 0; p < mib_pkg::NPORT; p++)
      begin
         a = mib_pkg::ADDR_PORT_BASE + mib_pkg::PORT_STRIDE * 12'(p);
         if (s_axi_araddr == a)
         begin
            // Index, enable, progress, overflow and high value bits.
            rd_word = {ovf_rd_q[p], 5'h00, busy_q[p], en_q[p], idx_q[p],
                       12'h000, hi_q[p]};
            rd_ok   = 1'b1;
         end
         if (s_axi_araddr == a + mib_pkg::DATA_OFS)
         begin
            rd_word = data_q[p];
            rd_ok   = 1'b1;
         end
         if (awaddr_q == a)
         begin
            csr_wr[p] = wr_fire;
            wr_ok     = 1'b1;
         end
         if (awaddr_q == a + mib_pkg::DATA_OFS)
         begin
            wr_ok = 1'b1;
         end
      end
   end

   // *********************************************************************
   // Switch-wide control and interrupts
   // *********************************************************************
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         sw_ctrl_q <= 8'h00;
      end
      else if (ce && wr_fire && wstrb_q[0] &&
               awaddr_q == mib_pkg::ADDR_SW_CTRL)
      begin
         sw_ctrl_q <= wdata_q[7:0];
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         irq_stat_q <= '0;
         irq_mask_q <= '0;
      end
      else if (ce)
      begin
         if (wr_fire && awaddr_q == mib_pkg::ADDR_IRQ_STAT)
         begin
            irq_stat_q <= (irq_stat_q & ~wdata_q[mib_pkg::IRQ_W-1:0])
                          | irq_evt;
         end
         else
         begin
            irq_stat_q <= irq_stat_q | irq_evt;
         end
         if (wr_fire && awaddr_q == mib_pkg::ADDR_IRQ_MASK)
         begin
            irq_mask_q <= mask_wr[mib_pkg::IRQ_W-1:0];
         end
      end
   end

   assign mask_wr = merge(32'(irq_mask_q), wdata_q, wstrb_q);
   assign irq     = |(irq_stat_q & irq_mask_q);

   // *********************************************************************
   // Per-port access registers and counters
   // *********************************************************************
   for (genvar p = 0; p < mib_pkg::NPORT; p++)
   begin : g_port
      logic [mib_pkg::CNT_W-1:0] sel_val;
      logic                      sel_ovf;

      // Freeze and flush reach only ports whose enable is set.
      assign hold[p]      = en_q[p] & sw_ctrl_q[mib_pkg::SW_FREEZE_BIT];
      assign clear_all[p] = en_q[p] & sw_ctrl_q[mib_pkg::SW_FLUSH_BIT];
      assign {sel_ok[p], sel_slot[p]} = slot_of(idx_q[p]);
      assign irq_evt[p]   = busy_q[p];
      assign irq_evt[mib_pkg::NPORT+p] = |wrap[p];

      always_comb
      begin
         sel_val = '0;
         sel_ovf = 1'b0;
         for (int s = 0; s < mib_pkg::NSLOT; s++)
         begin
            if (sel_ok[p] && sel_slot[p] == mib_pkg::SLOT_W'(s))
            begin
               sel_val = cnt_q[p][s];
               sel_ovf = ovf_q[p][s];
            end
         end
      end

      always_ff @(posedge sys_clk or posedge rst)
      begin
         if (rst)
         begin
            en_q[p]     <= 1'b0;
            idx_q[p]    <= 8'h00;
            busy_q[p]   <= 1'b0;
            data_q[p]   <= mib_pkg::RST_WORD;
            hi_q[p]     <= 4'h0;
            ovf_rd_q[p] <= 1'b0;
         end
         else if (ce)
         begin
            if (busy_q[p])
            begin
               data_q[p]   <= sel_val[31:0];
               hi_q[p]     <= sel_val[mib_pkg::CNT_W-1:32];
               ovf_rd_q[p] <= sel_ovf;
               busy_q[p]   <= 1'b0;
            end
            else if (csr_wr[p])
            begin
               if (wstrb_q[2])
               begin
                  idx_q[p] <= wdata_q[mib_pkg::CSR_IDX_LSB +: 8];
               end
               if (wstrb_q[3])
               begin
                  en_q[p]   <= wdata_q[mib_pkg::CSR_EN_BIT];
                  busy_q[p] <= wdata_q[mib_pkg::CSR_START_BIT];
               end
            end
         end
      end

      for (genvar s = 0; s < mib_pkg::NSLOT; s++)
      begin : g_slot
         localparam bit IS_BYTE = (s == mib_pkg::SLOT_RX_BYTES) ||
                                  (s == mib_pkg::SLOT_TX_BYTES);
         localparam int W = IS_BYTE ? mib_pkg::CNT_W : mib_pkg::SHORT_W;
         logic [mib_pkg::CNT_W:0]   inc;
         logic [mib_pkg::CNT_W:0]   sum;
         logic [mib_pkg::CNT_W-1:0] lim;
         logic                      count;
         logic                      hit;

         assign lim = ~({mib_pkg::CNT_W{1'b1}} << W);
         assign inc = (s == mib_pkg::SLOT_RX_BYTES) ?
                         (mib_pkg::CNT_W+1)'(rx_bytes[p*mib_pkg::BYTE_W +:
                                                      mib_pkg::BYTE_W]) :
                      (s == mib_pkg::SLOT_TX_BYTES) ?
                         (mib_pkg::CNT_W+1)'(tx_bytes[p*mib_pkg::BYTE_W +:
                                                      mib_pkg::BYTE_W]) :
                         (mib_pkg::CNT_W+1)'(1);
         assign sum   = {1'b0, cnt_q[p][s]} + inc;
         assign count = cnt_evt[p*mib_pkg::NSLOT+s] & ~hold[p];
         assign hit   = busy_q[p] & sel_ok[p] &
                        (sel_slot[p] == mib_pkg::SLOT_W'(s));
         assign wrap[p][s] = count & ~hit & ~clear_all[p] & sum[W];

         always_ff @(posedge sys_clk or posedge rst)
         begin
            if (rst)
            begin
               cnt_q[p][s] <= '0;
               ovf_q[p][s] <= 1'b0;
            end
            else if (ce)
            begin
               if (clear_all[p])
               begin
                  cnt_q[p][s] <= '0;
                  ovf_q[p][s] <= 1'b0;
               end
               else if (hit)
               begin
                  // Read clears, but keeps an event landing in that cycle.
                  cnt_q[p][s] <= count ? inc[mib_pkg::CNT_W-1:0] & lim
                                       : '0;
                  ovf_q[p][s] <= 1'b0;
               end
               else if (count)
               begin
                  cnt_q[p][s] <= sum[mib_pkg::CNT_W-1:0] & lim;
                  ovf_q[p][s] <= ovf_q[p][s] | sum[W];
               end
            end
         end
      end
   end

endmodule

`default_nettype wire

// ==== tb/mib_counter_access_freeze_properties.sv ====
// Bus, reset and interrupt properties of the statistics counter block.
// Assumes it is bound to the ports of the block's top module.
`timescale 1ns/1ns
`default_nettype none

module mib_props
(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        irq
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // ******************************************************************
   // Assertions
   // ******************************************************************
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("Write answer missing.");
   a_write_single: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("Write taken during answer.");
   a_bvalid_drop: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("Write answer stuck.");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read answer missing.");
   a_read_single: assert property (
      s_axi_rvalid |-> !s_axi_arready) else $error("Read taken twice.");
   a_rvalid_drop: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("Read answer stuck.");
   a_read_unmapped: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr[11:8] == 4'h2
      |=> s_axi_rresp == mib_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("Unmapped read not refused.");
   a_ctrl_okay: assert property (
      s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == mib_pkg::ADDR_SW_CTRL
      |=> s_axi_rresp == mib_pkg::RESP_OKAY)
      else $error("Switch control read refused.");
   a_ce_stall: assert property (
      !ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
      else $error("Ready while clock enable low.");
   a_reset_idle: assert property (
      $fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
      else $error("Outputs busy after reset.");

   c_irq: cover property (irq);
   c_ce_low: cover property (!ce);
   c_refused: cover property (s_axi_rvalid && s_axi_rresp[1]);
endmodule

bind mib_counter_access_freeze mib_props mib_props_i
(
   .sys_clk, .rst, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .irq
);

`default_nettype wire

// ==== tb/mib_counter_access_freeze_tb.sv ====
// Self-checking bench of the statistics counter block.
// Assumes the package and the block are compiled first.
`timescale 1ns/1ns
`default_nettype none

module mib_counter_access_freeze_tb;
   localparam int NP = mib_pkg::NPORT;
   localparam int NS = mib_pkg::NSLOT;
   localparam int BW = mib_pkg::BYTE_W;
   logic              sys_clk, rst, ce, irq;
   logic [NP*NS-1:0]  cnt_evt;
   logic [NP*BW-1:0]  rx_bytes, tx_bytes;
   logic [11:0]       s_axi_awaddr, s_axi_araddr;
   logic [31:0]       s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0]        s_axi_wstrb;
   logic [1:0]        s_axi_bresp, s_axi_rresp, rresp_s;
   logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic              s_axi_rready, ovf;
   logic [35:0]       v, e0, e1, d;
   int                error_cnt, tests_run, cyc, s, n;

   mib_counter_access_freeze mib_counter_access_freeze_i
   (
      .sys_clk, .rst, .ce, .cnt_evt, .rx_bytes, .tx_bytes, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq
   );

   // ******************************************************************
   // Expectation helpers
   // ******************************************************************
   function automatic logic [11:0] csr(input int p);
      return mib_pkg::ADDR_PORT_BASE + 12'(p) * mib_pkg::PORT_STRIDE;
   endfunction

   function automatic logic [11:0] dat(input int p);
      return csr(p) + mib_pkg::DATA_OFS;
   endfunction

   function automatic logic [31:0] csr_word(input logic go, input logic en,
                                            input logic [7:0] idx);
      return {6'h00, go, en, idx, 16'h0000};
   endfunction

   function automatic logic [7:0] slot_idx(input int sl);
      return (sl < 32) ? 8'(sl) : mib_pkg::IDX_HIGH_BASE + 8'(sl - 32);
   endfunction

   // ******************************************************************
   // Checking and closing
   // ******************************************************************
   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ******************************************************************
   // Bus and event drivers
   // ******************************************************************
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] dw,
                         input logic [3:0] st);
      int k;
      k = 0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= dw;
      s_axi_wstrb   <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         k++;
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid && k < 40);
      chk(s_axi_bresp, mib_pkg::RESP_OKAY);
   endtask

   task automatic axi_rd(input logic [11:0] a);
      int k;
      k = 0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         k++;
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid && k < 40);
      rdat    = s_axi_rdata;
      rresp_s = s_axi_rresp;
   endtask

   task automatic evts(input int p, input int sl, input int cnt,
                       inout logic [35:0] e);
      logic [BW-1:0] amt;
      for (int i = 0; i < cnt; i++)
      begin
         amt = BW'($urandom);
         cnt_evt[p*NS+sl] <= 1'b1;
         rx_bytes[p*BW +: BW] <= amt;
         tx_bytes[p*BW +: BW] <= amt;
         if (sl == mib_pkg::SLOT_RX_BYTES || sl == mib_pkg::SLOT_TX_BYTES)
            e = e + 36'(amt);
         else
            e = e + 36'h0_0000_0001;
         @(posedge sys_clk);
         cnt_evt <= '0;
         @(posedge sys_clk);
      end
   endtask

   task automatic rdcnt(input int p, input logic [7:0] idx, input logic en);
      int k;
      k = 0;
      axi_wr(csr(p), csr_word(1'b0, en, idx), 4'h4);
      axi_wr(csr(p), csr_word(1'b1, en, idx), 4'h8);
      do
      begin
         axi_rd(csr(p));
         k++;
      end
      while (rdat[mib_pkg::CSR_START_BIT] && k < 8);
      chk(rdat[mib_pkg::CSR_START_BIT], 1'b0);
      v[35:32] = rdat[3:0];
      ovf      = rdat[mib_pkg::CSR_OVF_BIT];
      axi_rd(dat(p));
      v[31:0]  = rdat;
   endtask

   // ******************************************************************
   // Clock, timeout and main sequence
   // ******************************************************************
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         error_cnt++;
         complete_run();
      end
   end

   initial
   begin
      rst = 1'b1; ce = 1'b1; cnt_evt = '0; rx_bytes = '0; tx_bytes = '0;
      s_axi_awaddr = 12'h000; s_axi_araddr = 12'h000; s_axi_wdata = '0;
      s_axi_wstrb = 4'hf; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0;
      s_axi_arvalid = 1'b0; s_axi_bready = 1'b1; s_axi_rready = 1'b1;
      error_cnt = 0; tests_run = 0; cyc = 0;
      void'($urandom(32'h0000_a5f1));
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      axi_rd(mib_pkg::ADDR_SW_CTRL);
      chk(rdat, 36'h0);
      for (int p = 0; p < NP; p++)
      begin
         axi_rd(csr(p));
         chk(rdat, 36'h0);
      end
      axi_rd(12'h200);
      chk(rresp_s, mib_pkg::RESP_SLVERR);
      for (int p = 0; p < NP; p++)
         for (int k = 0; k < 4; k++)
         begin
            s  = (k == 0) ? 32 + p : $urandom_range(NS - 1, 0);
            n  = $urandom_range(12, 1);
            e0 = '0;
            evts(p, s, n, e0);
            rdcnt(p, slot_idx(s), 1'b0);
            chk(v, e0);
            chk(ovf, 1'b0);
            rdcnt(p, slot_idx(s), 1'b0);
            chk(v, 36'h0);
         end
      axi_rd(mib_pkg::ADDR_IRQ_STAT);
      chk(rdat, 36'h7);
      chk(irq, 1'b0);
      axi_wr(mib_pkg::ADDR_IRQ_MASK, 32'h0000_0002, 4'hf);
      chk(irq, 1'b1);
      axi_wr(mib_pkg::ADDR_IRQ_STAT, 32'h0000_0002, 4'hf);
      chk(irq, 1'b0);
      axi_rd(mib_pkg::ADDR_IRQ_STAT);
      chk(rdat, 36'h5);
      e0 = '0; e1 = '0; d = '0;
      axi_wr(csr(0), csr_word(1'b0, 1'b1, 8'h00), 4'h8);
      evts(0, 5, 2, d);
      evts(1, 5, 2, e1);
      axi_wr(mib_pkg::ADDR_SW_CTRL, 32'h0000_0040, 4'hf);
      evts(0, 5, 3, d);
      evts(1, 5, 3, e1);
      axi_wr(mib_pkg::ADDR_SW_CTRL, 32'h0000_00c0, 4'hf);
      axi_wr(mib_pkg::ADDR_SW_CTRL, 32'h0000_0000, 4'hf);
      evts(0, 5, 4, e0);
      evts(1, 5, 4, e1);
      axi_wr(mib_pkg::ADDR_SW_CTRL, 32'h0000_0040, 4'hf);
      evts(0, 5, 1, d);
      evts(1, 5, 1, e1);
      rdcnt(0, 8'h05, 1'b1);
      chk(v, e0);
      rdcnt(1, 8'h05, 1'b0);
      chk(v, e1);
      ce <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk(s_axi_arready, 1'b0);
      ce <= 1'b1;
      @(posedge sys_clk);
      complete_run();
   end
endmodule

`default_nettype wire
